// ### design/hub_cfg_map.svh
`ifndef HUB_CFG_MAP_SVH
`define HUB_CFG_MAP_SVH

// Register indices (printed offsets, not multiples of four): byte address = 4 * index
`define SERIAL_TEXT_FIRST 8'h92
`define SERIAL_TEXT_LAST 8'hcf
`define SERIAL_LENGTH_IDX 8'h15
`define CHARGE_ENABLE_IDX 8'hd0
`define UP_DRIVE_IDX 8'hf6
`define DN_DRIVE_IDX 8'hf8
`define PIN_SWAP_IDX 8'hfa

// Field layout
`define CHARGE_P1_BIT 1
`define CHARGE_P2_BIT 2
`define SWAP_UP_BIT 0
`define SWAP_P1_BIT 1
`define SWAP_P2_BIT 2
`define SERIAL_LEN_MAX 8'h1f
`define SERIAL_TEXT_BYTES 62

// Writable masks; reserved bits read zero
`define CHARGE_MASK 8'h06
`define UP_DRIVE_MASK 8'h03
`define DN_DRIVE_MASK 8'h0f
`define SWAP_MASK 8'h07
`define RESET_BYTE 8'h00

`endif

// ### design/hub_cfg_pkg.sv
package hub_cfg_pkg;

    typedef enum logic [1:0] {
        BOOST_NORMAL = 2'b00,
        BOOST_PLUS4 = 2'b01,
        BOOST_PLUS8 = 2'b10,
        BOOST_PLUS12 = 2'b11
    } boost_level_t;

    typedef struct packed {
        boost_level_t upstream_boost_level;
        boost_level_t port1_boost_level;
        boost_level_t port2_boost_level;
    } drive_cfg_t;

    typedef struct packed {
        logic up_swap;
        logic port1_swap;
        logic port2_swap;
    } swap_cfg_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_RESP = 2'b01
    } rd_state_t;

endpackage

// ### design/hub_port_config_registers.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "hub_cfg_map.svh"

// Notes on behaviour
// - Serial text bytes 0x92-0xcf, read/write, reset zero
// - Length register in characters, max 31, reset zero; any written value is stored without clamping
// - Charge enable bits 2 and 1 per port
// - Charge enable one activates charging on port
// - Upstream boost field bits 1:0, reset 00
// - Boost codes: normal, +4, +8, +12 percent
// - Port 2 boost bits 3:2, upper reserved
// - Port 1 boost bits 1:0, reset 00
// - Swap bits: 0 upstream, 1 port1, 2 port2
// - Swap one exchanges positive and negative pins
module hub_port_config_registers (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] port_charge_enable_q,
    output hub_cfg_pkg::drive_cfg_t drive_cfg_q,
    output hub_cfg_pkg::swap_cfg_t pin_swap_q,
    output logic [7:0] serial_number_length_q,
    input wire logic [5:0] serial_text_rd_index,
    output logic [7:0] serial_text_rd_byte_q
);

    // ==========================================================
    // Decode helpers
    // ==========================================================
    // Index from a byte address; misaligned or out-of-map addresses decode as unmapped except for read data, which still follows index bits 9:2
    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a[31:10] == 22'h000000);
    endfunction

    function automatic logic is_text(input logic [7:0] idx);
        is_text = (idx >= `SERIAL_TEXT_FIRST) && (idx <= `SERIAL_TEXT_LAST);
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = is_text(idx) || idx == `SERIAL_LENGTH_IDX || idx == `CHARGE_ENABLE_IDX
            || idx == `UP_DRIVE_IDX || idx == `DN_DRIVE_IDX || idx == `PIN_SWAP_IDX;
    endfunction

    // ==========================================================
    // Register storage
    // ==========================================================
    logic [7:0] serial_text_q [0:`SERIAL_TEXT_BYTES-1];
    logic [7:0] charge_q;
    logic [7:0] up_drive_q;
    logic [7:0] dn_drive_q;
    logic [7:0] swap_q;
    logic [7:0] length_q;

    // ==========================================================
    // Write channel
    // ==========================================================
    logic aw_held_q;
    logic w_held_q;
    logic [31:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic do_write;
    logic [7:0] widx;
    logic wok;

    // Address and data are accepted in either order; the write lands once both are held
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign widx = awaddr_q[9:2];
    assign wok = addr_ok(awaddr_q) && mapped(widx);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 32'h00000000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            w_held_q <= 1'b0;
            wbyte_q <= `RESET_BYTE;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only lane 0 carries the byte-wide register; other lanes are ignored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < `SERIAL_TEXT_BYTES; i++) begin
                serial_text_q[i] <= `RESET_BYTE;
            end
        end else if (do_write && wok && wlane_q && is_text(widx)) begin
            serial_text_q[6'(widx - `SERIAL_TEXT_FIRST)] <= wbyte_q;
        end
    end

    // Length is stored as written; software keeps it within the maximum of 31
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            length_q <= `RESET_BYTE;
        end else if (do_write && wok && wlane_q && widx == `SERIAL_LENGTH_IDX) begin
            length_q <= wbyte_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            charge_q <= `RESET_BYTE;
            up_drive_q <= `RESET_BYTE;
            dn_drive_q <= `RESET_BYTE;
            swap_q <= `RESET_BYTE;
        end else if (do_write && wok && wlane_q) begin
            if (widx == `CHARGE_ENABLE_IDX) begin
                charge_q <= wbyte_q & `CHARGE_MASK;
            end
            if (widx == `UP_DRIVE_IDX) begin
                up_drive_q <= wbyte_q & `UP_DRIVE_MASK;
            end
            if (widx == `DN_DRIVE_IDX) begin
                dn_drive_q <= wbyte_q & `DN_DRIVE_MASK;
            end
            if (widx == `PIN_SWAP_IDX) begin
                swap_q <= wbyte_q & `SWAP_MASK;
            end
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    hub_cfg_pkg::rd_state_t rd_state_q;
    logic [7:0] ridx;
    logic [7:0] rbyte;

    assign ridx = s_axi_araddr[9:2];

    always_comb begin
        rbyte = `RESET_BYTE;
        if (is_text(ridx)) begin
            rbyte = serial_text_q[6'(ridx - `SERIAL_TEXT_FIRST)];
        end else begin
            case (ridx)
                `SERIAL_LENGTH_IDX: rbyte = length_q;
                `CHARGE_ENABLE_IDX: rbyte = charge_q;
                `UP_DRIVE_IDX: rbyte = up_drive_q;
                `DN_DRIVE_IDX: rbyte = dn_drive_q;
                `PIN_SWAP_IDX: rbyte = swap_q;
                default: rbyte = `RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_state_q <= hub_cfg_pkg::RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            case (rd_state_q)
                hub_cfg_pkg::RD_IDLE: begin
                    s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
                    if (s_axi_arvalid && s_axi_arready) begin
                        rd_state_q <= hub_cfg_pkg::RD_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= {24'h000000, rbyte};
                        s_axi_rresp <= (addr_ok(s_axi_araddr) && mapped(ridx)) ? 2'b00 : 2'b10;
                    end
                end
                hub_cfg_pkg::RD_RESP: begin
                    s_axi_arready <= 1'b0;
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state_q <= hub_cfg_pkg::RD_IDLE;
                    end
                end
                default: rd_state_q <= hub_cfg_pkg::RD_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Configuration outputs to port logic
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_charge_enable_q <= 2'b00;
            drive_cfg_q <= '0;
            pin_swap_q <= '0;
            serial_number_length_q <= `RESET_BYTE;
            serial_text_rd_byte_q <= `RESET_BYTE;
        end else begin
            port_charge_enable_q <= {charge_q[`CHARGE_P2_BIT], charge_q[`CHARGE_P1_BIT]};
            drive_cfg_q.upstream_boost_level <= hub_cfg_pkg::boost_level_t'(up_drive_q[1:0]);
            drive_cfg_q.port1_boost_level <= hub_cfg_pkg::boost_level_t'(dn_drive_q[1:0]);
            drive_cfg_q.port2_boost_level <= hub_cfg_pkg::boost_level_t'(dn_drive_q[3:2]);
            pin_swap_q.up_swap <= swap_q[`SWAP_UP_BIT];
            pin_swap_q.port1_swap <= swap_q[`SWAP_P1_BIT];
            pin_swap_q.port2_swap <= swap_q[`SWAP_P2_BIT];
            serial_number_length_q <= length_q;
            // Index beyond 61 returns zero rather than aliasing
            serial_text_rd_byte_q <= (serial_text_rd_index < 6'd62) ?
                serial_text_q[serial_text_rd_index] : `RESET_BYTE;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_charge_out;
        @(posedge clk) disable iff (!rst_b)
        ##1 port_charge_enable_q == {$past(charge_q[2]), $past(charge_q[1])};
    endproperty
    a_charge_out: assert property (p_charge_out) else $error("charge enable mismatch");

    property p_charge_reserved;
        @(posedge clk) disable iff (!rst_b)
        (charge_q & ~`CHARGE_MASK) == 8'h00;
    endproperty
    a_charge_reserved: assert property (p_charge_reserved) else $error("charge reserved set");

    property p_up_reserved;
        @(posedge clk) disable iff (!rst_b)
        up_drive_q[7:2] == 6'h00;
    endproperty
    a_up_reserved: assert property (p_up_reserved) else $error("upstream reserved set");

    property p_dn_reserved;
        @(posedge clk) disable iff (!rst_b)
        dn_drive_q[7:4] == 4'h0;
    endproperty
    a_dn_reserved: assert property (p_dn_reserved) else $error("downstream reserved set");

    property p_port1_boost;
        @(posedge clk) disable iff (!rst_b)
        ##1 drive_cfg_q.port1_boost_level == $past(dn_drive_q[1:0]);
    endproperty
    a_port1_boost: assert property (p_port1_boost) else $error("port1 boost mismatch");

    property p_up_boost;
        @(posedge clk) disable iff (!rst_b)
        ##1 drive_cfg_q.upstream_boost_level == $past(up_drive_q[1:0]);
    endproperty
    a_up_boost: assert property (p_up_boost) else $error("upstream boost mismatch");

    property p_swap_out;
        @(posedge clk) disable iff (!rst_b)
        ##1 pin_swap_q == {$past(swap_q[`SWAP_UP_BIT]), $past(swap_q[`SWAP_P1_BIT]),
            $past(swap_q[`SWAP_P2_BIT])};
    endproperty
    a_swap_out: assert property (p_swap_out) else $error("swap mismatch");

    property p_rdata_high_zero;
        @(posedge clk) disable iff (!rst_b)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rdata_high_zero: assert property (p_rdata_high_zero) else $error("upper read bits set");

    property p_text_write;
        @(posedge clk) disable iff (!rst_b)
        (do_write && wok && wlane_q && is_text(widx)) |=>
            serial_text_q[6'($past(widx) - `SERIAL_TEXT_FIRST)] == $past(wbyte_q);
    endproperty
    a_text_write: assert property (p_text_write) else $error("text byte not stored");

    property p_len_write;
        @(posedge clk) disable iff (!rst_b)
        (do_write && wok && wlane_q && widx == `SERIAL_LENGTH_IDX) |=> length_q == $past(wbyte_q);
    endproperty
    a_len_write: assert property (p_len_write) else $error("length not stored");

endmodule

// ### dv/tb_hub_port_config_registers.sv
`timescale 1ns/100ps
`include "hub_cfg_map.svh"

module tb_hub_port_config_registers;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wr;
        logic [7:0] rd;
    } row_t;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [1:0] port_charge_enable_q;
    hub_cfg_pkg::drive_cfg_t drive_cfg_q;
    hub_cfg_pkg::swap_cfg_t pin_swap_q;
    logic [7:0] serial_number_length_q;
    logic [5:0] serial_text_rd_index = 6'h0;
    logic [7:0] serial_text_rd_byte_q;
    int n_fail = 0;
    int total_checks = 0;
    logic [1:0] c;
    row_t rows [7];

    always #5 clk = ~clk;

    hub_port_config_registers dut_u (
        .clk(clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .port_charge_enable_q(port_charge_enable_q),
        .drive_cfg_q(drive_cfg_q), .pin_swap_q(pin_swap_q),
        .serial_number_length_q(serial_number_length_q),
        .serial_text_rd_index(serial_text_rd_index),
        .serial_text_rd_byte_q(serial_text_rd_byte_q)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // A stuck handshake leaves resp unknown, so the compare after it fails
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic [1:0] resp;
        logic done;
        resp = 2'bxx;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'hffffff, d};
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                resp = s_axi_bresp;
                done = 1'b1;
            end
        end
        chk({30'h0, resp}, {30'h0, er}, "write response");
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic [31:0] data;
        logic [1:0] resp;
        logic done;
        data = 32'hx;
        resp = 2'bxx;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                done = 1'b1;
            end
        end
        chk(data, {24'h0, ed}, "read data");
        chk({30'h0, resp}, {30'h0, er}, "read response");
    endtask

    function automatic logic [31:0] addr_of(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction

    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the full run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    // ==========================================================
    // Tests
    initial begin
        rows = '{'{8'hd0, 8'hff, 8'h06}, '{8'hf6, 8'hff, 8'h03}, '{8'hf8, 8'hff, 8'h0f},
                 '{8'hfa, 8'hff, 8'h07}, '{8'h15, 8'h1f, 8'h1f}, '{8'h92, 8'ha5, 8'ha5},
                 '{8'hcf, 8'h5a, 8'h5a}};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) rd(addr_of(rows[i].idx), 8'h00, 2'b00);
        foreach (rows[i]) begin
            wr(addr_of(rows[i].idx), rows[i].wr, 4'h1, 2'b00);
            rd(addr_of(rows[i].idx), rows[i].rd, 2'b00);
        end
        repeat (2) @(posedge clk);
        chk({24'h0, serial_number_length_q}, 32'h1f, "length out");
        // Strobe low must leave the stored value alone
        wr(addr_of(`CHARGE_ENABLE_IDX), 8'h00, 4'h0, 2'b00);
        rd(addr_of(`CHARGE_ENABLE_IDX), 8'h06, 2'b00);
        // Unmapped index and misaligned byte address
        wr(addr_of(8'h16), 8'h11, 4'h1, 2'b10);
        rd(addr_of(8'h16), 8'h00, 2'b10);
        wr(32'h341, 8'h00, 4'h1, 2'b10);
        rd(addr_of(`CHARGE_ENABLE_IDX), 8'h06, 2'b00);
        // Single-bit walk over charge and swap registers
        for (int b = 0; b < 8; b++) begin
            wr(addr_of(`CHARGE_ENABLE_IDX), 8'h01 << b, 4'h1, 2'b00);
            wr(addr_of(`PIN_SWAP_IDX), 8'h01 << b, 4'h1, 2'b00);
            repeat (2) @(posedge clk);
            chk({30'h0, port_charge_enable_q}, {30'h0, b == 2, b == 1}, "charge");
            chk({29'h0, pin_swap_q}, {29'h0, b == 0, b == 1, b == 2}, "swap");
            rd(addr_of(`PIN_SWAP_IDX), (8'h01 << b) & 8'h07, 2'b00);
        end
        // Every boost code on every field, reserved bits set
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(addr_of(`UP_DRIVE_IDX), {6'h3f, c}, 4'h1, 2'b00);
            wr(addr_of(`DN_DRIVE_IDX), {4'hf, c, ~c}, 4'h1, 2'b00);
            repeat (2) @(posedge clk);
            chk({26'h0, drive_cfg_q}, {26'h0, c, ~c, c}, "boost");
            rd(addr_of(`DN_DRIVE_IDX), {4'h0, c, ~c}, 2'b00);
        end
        // UTF-16LE text, high byte nonzero so a lane swap shows
        for (int i = 0; i < 62; i++) begin
            wr(addr_of(`SERIAL_TEXT_FIRST + 8'(i)),
               i[0] ? 8'h04 : 8'h10 + 8'(i), 4'h1, 2'b00);
        end
        rd(addr_of(`SERIAL_TEXT_FIRST), 8'h10, 2'b00);
        rd(addr_of(`SERIAL_TEXT_LAST), 8'h04, 2'b00);
        for (int i = 0; i < 63; i++) begin
            serial_text_rd_index <= 6'(i);
            repeat (2) @(posedge clk);
            chk({24'h0, serial_text_rd_byte_q},
                (i > 61) ? 32'h0 : (i[0] ? 32'h04 : 32'h10 + i), "text port");
        end
        // Reset in mid-run clears every field; load nonzero values first so the check bites
        wr(addr_of(`CHARGE_ENABLE_IDX), 8'h06, 4'h1, 2'b00);
        wr(addr_of(`PIN_SWAP_IDX), 8'h07, 4'h1, 2'b00);
        serial_text_rd_index <= 6'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk({21'h0, port_charge_enable_q, drive_cfg_q, pin_swap_q}, 32'h0, "outs");
        chk({16'h0, serial_number_length_q, serial_text_rd_byte_q}, 32'h0, "outs2");
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) rd(addr_of(rows[i].idx), 8'h00, 2'b00);
        wrap_up();
    end
endmodule
